// >>> bench/pmic_system_control_i2c_test.sv
/*
  Self-checking bench: register link, button, reset timer and enables.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
`include "psc_cfg.svh"
module pmic_system_control_i2c_test;
  localparam int unsigned RC = 20;
  localparam logic [6:0] DV = `PSC_TARGET_ADDR;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic button_request_in_n = 1'b1;
  logic button_hard_reset = 1'b0;
  logic channel_enable_first = 1'b0;
  logic channel_enable_second = 1'b0;
  logic channel_enable_third = 1'b0;
  logic first_buck_in_regulation = 1'b0;
  logic scl, sda_low, sda_out, sda_oe;
  logic system_reset_out_n, host_interrupt_out_n, system_enabled;
  logic [7:0] q, d;
  logic ak;
  int err_count = 0;
  int n_compared = 0;
  int seed = 89;
  // wired-and sda with pull-up
  wire sda_in = !(sda_low || (sda_oe && !sda_out));
  always #5 clock = ~clock;
  psc_system_control #(.RESET_CYCLES(RC)) uut (
    .clock(clock),
    .resetn(resetn),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .button_request_in_n(button_request_in_n),
    .button_hard_reset(button_hard_reset),
    .channel_enable_first(channel_enable_first),
    .channel_enable_second(channel_enable_second),
    .channel_enable_third(channel_enable_third),
    .first_buck_in_regulation(first_buck_in_regulation),
    .system_reset_out_n(system_reset_out_n),
    .host_interrupt_out_n(host_interrupt_out_n),
    .system_enabled(system_enabled)
  );
  psc_host_model host (.clock(clock), .sda(sda_in), .scl(scl), .sda_low(sda_low));
  function automatic logic [7:0] sys_exp(input logic [7:0] v);
    return v & 8'h13; // only status, unmask, exact bits stored
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic press(input logic irq);
    button_request_in_n <= 1'b0;
    wt(8);
    chk(host_interrupt_out_n, irq);
    button_request_in_n <= 1'b1;
    wt(8);
  endtask
  task complete_run;
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, well past the expected run length
  initial
  begin
    #400000;
    err_count++;
    complete_run();
  end
  initial
  begin
    wt(5);
    resetn <= 1'b1;
    wt(5);
    chk(system_reset_out_n, 1'b0);
    chk(host_interrupt_out_n, 1'b1);
    first_buck_in_regulation <= 1'b1;
    wt(RC);
    chk(system_reset_out_n, 1'b0);
    wt(10);
    chk(system_reset_out_n, 1'b1);
    host.rd(DV, `PSC_SYS_OFFSET, q, ak);
    chk(ak, 1'b1);
    chk(q, `PSC_SYS_RESET);
    host.wr(DV ^ 7'h01, `PSC_SYS_OFFSET, 8'h00, ak);
    chk(ak, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      d = (i == 0) ? 8'hEF : 8'($random(seed)) & 8'hEF;
      host.wr(DV, `PSC_SYS_OFFSET, d, ak);
      chk(ak, 1'b1);
      host.rd(DV, `PSC_SYS_OFFSET, q, ak);
      chk(q, sys_exp(d));
    end
    host.wr(DV, `PSC_SYS_OFFSET, 8'h02, ak);
    button_request_in_n <= 1'b0;
    wt(8);
    chk(system_enabled, 1'b1);
    chk(system_reset_out_n, 1'b1);
    chk(host_interrupt_out_n, 1'b0);
    channel_enable_first <= 1'b1;
    wt(4);
    button_request_in_n <= 1'b1;
    wt(8);
    chk(system_enabled, 1'b1);
    host.rd(DV, `PSC_SYS_OFFSET, q, ak);
    chk(q, 8'h03);
    chk(host_interrupt_out_n, 1'b1);
    host.wr(DV, `PSC_SYS_OFFSET, 8'h00, ak);
    press(1'b1);
    host.rd(DV, `PSC_SYS_OFFSET, q, ak);
    chk(q, 8'h01);
    host.wr(DV, `PSC_SYS_OFFSET, 8'h02, ak);
    press(1'b0);
    host.rd(DV, `PSC_SYS_OFFSET, q, ak);
    chk(q, 8'h03);
    chk(host_interrupt_out_n, 1'b1);
    // host walks the channels down itself, each of the three in turn
    channel_enable_third <= 1'b1;
    channel_enable_first <= 1'b0;
    wt(8);
    chk(system_enabled, 1'b1);
    channel_enable_second <= 1'b1;
    channel_enable_third <= 1'b0;
    wt(8);
    chk(system_enabled, 1'b1);
    channel_enable_second <= 1'b0;
    wt(8);
    chk(system_enabled, 1'b0);
    button_hard_reset <= 1'b1;
    wt(1);
    button_request_in_n <= 1'b0;
    wt(4);
    chk(system_reset_out_n, 1'b0);
    wt(30);
    chk(system_reset_out_n, 1'b0);
    button_request_in_n <= 1'b1;
    wt(1);
    button_hard_reset <= 1'b0;
    wt(RC);
    chk(system_reset_out_n, 1'b0);
    wt(12);
    chk(system_reset_out_n, 1'b1);
    complete_run();
  end
endmodule // pmic_system_control_i2c_test

// >>> bench/psc_host_model.sv
/*
  Host-side serial master model: start, stop, byte transfers, register tasks.
  Assumes an open-drain sda with pull-up resolved by the bench.
*/
`timescale 1ns/100ps
module psc_host_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  // data moves only while scl is low; sampled mid-high
  task automatic bx(input logic b, output logic r);
    sda_low <= !b;
    tk(5);
    scl <= 1'b1;
    tk(1);
    r = sda;
    tk(1);
    scl <= 1'b0;
    tk(1);
  endtask
  // msb first, ninth bit released for the receiver
  task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bx(d[i], r);
      q[i] = r;
    end
    bx(1'b1, r);
    a = !r;
  endtask
  // also serves as repeated start
  task automatic st;
    sda_low <= 1'b0;
    // low time long enough for the target to release its ack first
    tk(4);
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b1;
    tk(4);
    scl <= 1'b0;
    tk(1);
  endtask
  task automatic sp;
    sda_low <= 1'b1;
    tk(4);
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b0;
    tk(4);
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] a, d, output logic ok);
    logic [7:0] q;
    logic a1, a2, a3;
    st();
    xb({dv, 1'b0}, q, a1);
    xb(a, q, a2);
    xb(d, q, a3);
    sp();
    ok = a1 & a2 & a3;
  endtask
  // host nacks the single data byte
  task automatic rd(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] q,
    output logic ok);
    logic [7:0] z;
    logic a1, a2, a3, n;
    st();
    xb({dv, 1'b0}, z, a1);
    xb(a, z, a2);
    st();
    xb({dv, 1'b1}, z, a3);
    xb(8'hFF, q, n);
    sp();
    ok = a1 & a2 & a3;
  endtask
endmodule // psc_host_model

// >>> bench/psc_system_control_chk.sv
/*
  Port-level checker of reset, enable, interrupt and sda timing.
  Assumes one clock domain; bound to psc_system_control below.
*/
`timescale 1ns/100ps
module psc_system_control_chk #(
  parameter int unsigned RESET_CYCLES = 20
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic button_request_in_n,
  input wire logic button_hard_reset,
  input wire logic channel_enable_first,
  input wire logic channel_enable_second,
  input wire logic channel_enable_third,
  input wire logic first_buck_in_regulation,
  input wire logic system_reset_out_n,
  input wire logic host_interrupt_out_n,
  input wire logic system_enabled
);
  logic hard;
  logic any_en;
  logic sda_q;
  int unsigned ok_cnt;
  int unsigned pr_cnt;
  int unsigned st_cnt;
  assign hard = button_hard_reset && !button_request_in_n;
  assign any_en = channel_enable_first | channel_enable_second | channel_enable_third;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // saturating ages; the cap keeps them from wrapping on long runs
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ok_cnt <= 0;
      pr_cnt <= 1000;
      st_cnt <= 1000;
      sda_q <= 1'b1;
    end
    else
    begin
      sda_q <= sda_in;
      ok_cnt <= (!first_buck_in_regulation || hard) ? 0 :
        (ok_cnt < RESET_CYCLES + 100) ? ok_cnt + 1 : ok_cnt;
      pr_cnt <= (!button_request_in_n && !button_hard_reset) ? 0 :
        (pr_cnt < 1000) ? pr_cnt + 1 : pr_cnt;
      st_cnt <= (scl && sda_q && !sda_in) ? 0 : (st_cnt < 1000) ? st_cnt + 1 : st_cnt;
    end
  end
  chk_pull_only: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("sda moved while scl high");
  chk_hard_low: assert property (hard [*4] |-> !system_reset_out_n)
    else $error("reset out high in hard press");
  chk_buck_low: assert property (!first_buck_in_regulation [*4] |-> !system_reset_out_n)
    else $error("reset out high with buck down");
  chk_delay_min: assert property ($rose(system_reset_out_n) |-> ok_cnt >= RESET_CYCLES)
    else $error("reset out released early");
  chk_delay_max: assert property (ok_cnt >= RESET_CYCLES + 8 |-> system_reset_out_n)
    else $error("reset out released late");
  chk_enable_hold: assert property (any_en [*4] ##0 system_enabled |=> system_enabled)
    else $error("enable dropped with a channel on");
  chk_irq_cause: assert property ($fell(host_interrupt_out_n) |-> pr_cnt <= 6)
    else $error("interrupt without press");
  chk_enable_cause: assert property ($rose(system_enabled) |-> pr_cnt <= 6)
    else $error("enable without press");
  chk_irq_poll: assert property ($rose(host_interrupt_out_n) |-> st_cnt <= 400)
    else $error("interrupt cleared without poll");
  cover property ($fell(host_interrupt_out_n));
  cover property ($rose(system_reset_out_n));
  cover property ($fell(system_enabled));
endmodule // psc_system_control_chk
bind psc_system_control psc_system_control_chk #(.RESET_CYCLES(RESET_CYCLES)) chk (.*);

// >>> hdl/psc_i2c_target.sv
/*
  Serial-link target: byte reads and writes of the register file.
  Assumes scl and sda inputs are already synchronised to clock.
*/
`timescale 1ns/100ps
`include "psc_cfg.svh"
module psc_i2c_target (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_sync,
  input wire logic sda_sync,
  input wire logic [7:0] read_data,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] reg_addr,
  output logic [7:0] write_data,
  output logic write_strobe,
  output logic read_strobe
);
  import psc_pkg::*;
  typedef struct packed {
    psc_link_state_t state;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift;
    logic [3:0] count;
    logic is_read;
    logic have_addr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wstb;
    logic rstb;
    logic drive_low;
  } psc_tgt_t;
  psc_tgt_t cur, next_cur;
  logic rise, fall, start_c, stop_c;

  // edges of the link clock and bus conditions
  assign rise = scl_sync & ~cur.scl_q;
  assign fall = ~scl_sync & cur.scl_q;
  assign start_c = scl_sync & cur.scl_q & cur.sda_q & ~sda_sync;
  assign stop_c = scl_sync & cur.scl_q & ~cur.sda_q & sda_sync;

  // only ever pulls sda, never clocks the bus: target role
  assign sda_out = 1'b0;
  assign sda_oe = cur.drive_low;
  assign reg_addr = cur.addr;
  assign write_data = cur.wdata;
  assign write_strobe = cur.wstb;
  assign read_strobe = cur.rstb;

  always_comb
  begin
    next_cur = cur;
    next_cur.scl_q = scl_sync;
    next_cur.sda_q = sda_sync;
    next_cur.wstb = 1'b0;
    next_cur.rstb = 1'b0;
    if (start_c)
    begin
      next_cur.state = PSC_ADDR;
      next_cur.count = 4'h0;
      next_cur.drive_low = 1'b0;
    end
    else if (stop_c)
    begin
      next_cur.state = PSC_IDLE;
      next_cur.drive_low = 1'b0;
    end
    else
    begin
      case (cur.state)
        PSC_IDLE: next_cur.drive_low = 1'b0;
        PSC_ADDR, PSC_WR_BYTE:
          if (rise)
          begin
            next_cur.shift = {cur.shift[6:0], sda_sync};
            next_cur.count = cur.count + 4'h1;
          end
          else if (fall && cur.count == 4'h8)
          begin
            next_cur.count = 4'h0;
            if (cur.state == PSC_ADDR)
            begin
              if (cur.shift[7:1] == `PSC_TARGET_ADDR)
              begin
                next_cur.is_read = cur.shift[0];
                next_cur.drive_low = 1'b1;
                next_cur.state = PSC_ADDR_ACK;
                if (cur.shift[0])
                  next_cur.rstb = 1'b1;
              end
              else
                next_cur.state = PSC_IDLE;
            end
            else
            begin
              if (!cur.have_addr)
                next_cur.addr = cur.shift;
              else
              begin
                next_cur.wdata = cur.shift;
                next_cur.wstb = 1'b1;
              end
              next_cur.have_addr = 1'b1;
              next_cur.drive_low = 1'b1;
              next_cur.state = PSC_WR_ACK;
            end
          end
        PSC_ADDR_ACK, PSC_WR_ACK:
          if (fall)
          begin
            next_cur.count = 4'h0;
            if (cur.state == PSC_ADDR_ACK && cur.is_read)
            begin
              next_cur.shift = read_data;
              next_cur.drive_low = ~read_data[7];
              next_cur.state = PSC_RD_BYTE;
            end
            else
            begin
              next_cur.drive_low = 1'b0;
              next_cur.have_addr = cur.state == PSC_WR_ACK;
              next_cur.state = PSC_WR_BYTE;
            end
          end
        PSC_RD_BYTE:
          if (fall)
          begin
            next_cur.count = cur.count + 4'h1;
            next_cur.shift = {cur.shift[6:0], 1'b0};
            if (cur.count == 4'h7)
            begin
              next_cur.drive_low = 1'b0;
              next_cur.state = PSC_RD_ACK;
            end
            else
              next_cur.drive_low = ~cur.shift[6];
          end
        PSC_RD_ACK:
          // the ninth clock ends the read, ack or nack alike; single-byte reads only
          if (rise)
            next_cur.state = PSC_IDLE;
        default: next_cur.state = PSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cur <= '{state: PSC_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    else
      cur <= next_cur;
  end
endmodule // psc_i2c_target

// >>> hdl/psc_system_control.sv
/*
  System-control block: serial register access, push-button handling,
  reset output timer and shutdown on release of all channel enables.
  Assumes one 100 MHz clock; pins arrive asynchronous and are synchronised.
  The hard-press pin comes from a ground-detect stage outside this block.
*/
`timescale 1ns/100ps
`include "psc_cfg.svh"
// What this block does
// - answers only at 7-bit target address 1011010 plus direction bit.
// - never drives the serial clock nor starts a transaction.
// - supports single-byte register writes and reads.
// - bytes are eight bits, msb first, sampled on rising serial clock.
// - target acknowledges its address and every byte written to it.
// - button press sets status bit 0 of system register.
// - bit 1 unmasks button interrupts onto the interrupt output.
// - bits 3:2 and 7:5 read-only, writes ignored.
// - second press after power-up raises interrupt as shutdown request.
// - system stays enabled until all three channel enables drop.
// - resistor press means startup or shutdown, not reset.
// - direct-ground press holds reset low until release plus 260 ms.
// - reset low while first buck out of regulation, then 260 ms more.
// - interrupt low until host polls over the serial link.
module psc_system_control #(
  parameter int unsigned RESET_CYCLES = `PSC_RESET_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic button_request_in_n,
  input wire logic button_hard_reset,
  input wire logic channel_enable_first,
  input wire logic channel_enable_second,
  input wire logic channel_enable_third,
  input wire logic first_buck_in_regulation,
  output logic system_reset_out_n,
  output logic host_interrupt_out_n,
  output logic system_enabled
);
  import psc_pkg::*;
  // reset timer word; wide enough for the full delay at the system clock
  typedef logic [`PSC_TIMER_BITS-1:0] psc_timer_t;
  localparam int unsigned TIMER_MAX = (32'h1 << `PSC_TIMER_BITS) - 32'h1;
  // last timer value before release; the timer stops there, never wraps
  localparam psc_timer_t TIMER_LAST = psc_timer_t'(RESET_CYCLES - 32'h1);
  // reset image of the system register, split into its stored fields
  localparam logic [7:0] SYS_RESET = `PSC_SYS_RESET;

  // refuse delays the timer cannot count: zero, or wider than the word
  if (RESET_CYCLES < 32'h1 || RESET_CYCLES > TIMER_MAX)
  begin : g_bad_reset_cycles
    $error("RESET_CYCLES out of range");
  end

  // whole state in one word: pin stages, register fields, sequencer
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] btn_s;
    logic [1:0] hard_s;
    logic [1:0] on_s;
    logic [1:0] reg_s;
    logic btn_q;
    logic status;
    logic unmask;
    logic exact;
    logic irq;
    logic powered;
    psc_sys_state_t system_pushbutton_control;
    psc_timer_t timer;
    logic rst_n;
  } psc_ctl_t;
  psc_ctl_t cur, next_cur;
  logic [7:0] reg_addr, write_data, read_data;
  logic write_strobe, read_strobe;
  logic pressed, any_on, hard_hold;
  logic press_edge, reset_hold;

  // link target; its inputs are already through two stages here
  // sda comes back through the pin, so the target also sees its own pull
  psc_i2c_target u_target (
    .clock(clock),
    .resetn(resetn),
    .scl_sync(cur.scl_s[1]),
    .sda_sync(cur.sda_s[1]),
    .read_data(read_data),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_addr(reg_addr),
    .write_data(write_data),
    .write_strobe(write_strobe),
    .read_strobe(read_strobe)
  );

  // synchronised pin levels
  assign pressed = cur.btn_s[1];
  assign any_on = cur.on_s[1];
  assign hard_hold = cur.hard_s[1];
  // resistor press edge; the hard-press pin must settle no later than the
  // button, or a direct-ground press is taken for one resistor press
  assign press_edge = pressed && !cur.btn_q && !hard_hold;
  // any cause that must keep the reset output low
  assign reset_hold = (hard_hold && pressed) || !cur.reg_s[1];

  // unknown addresses read zero; upper read-only bits read zero
  // read-only bits carry no state of their own, so zero costs nothing
  // the target latches this word on the address ack, one byte per read
  always_comb
  begin
    read_data = 8'h00;
    if (reg_addr == `PSC_SYS_OFFSET)
    begin
      read_data[`PSC_BIT_STATUS] = cur.status;
      read_data[`PSC_BIT_UNMASK] = cur.unmask;
      read_data[`PSC_BIT_EXACT] = cur.exact;
    end
  end

  // outputs straight from flops, so no glitch reaches the pins
  assign system_reset_out_n = cur.rst_n;
  assign host_interrupt_out_n = ~cur.irq;
  assign system_enabled = cur.system_pushbutton_control == PSC_SYS_ON;

  // next state: two stages on every pin before any logic reads it;
  // the enables are or-ed ahead of the stages since only any-on matters
  always_comb
  begin
    next_cur = cur;
    next_cur.scl_s = {cur.scl_s[0], scl};
    next_cur.sda_s = {cur.sda_s[0], sda_in};
    next_cur.btn_s = {cur.btn_s[0], ~button_request_in_n};
    next_cur.hard_s = {cur.hard_s[0], button_hard_reset};
    next_cur.on_s = {cur.on_s[0],
      channel_enable_first | channel_enable_second | channel_enable_third};
    next_cur.reg_s = {cur.reg_s[0], first_buck_in_regulation};
    next_cur.btn_q = pressed;

    // register writes: bits 3:2 and 7:5 never stored
    // bit 4 is stored as written; keeping it at its fixed value is the host's
    if (write_strobe && reg_addr == `PSC_SYS_OFFSET)
    begin
      next_cur.unmask = write_data[`PSC_BIT_UNMASK];
      next_cur.exact = write_data[`PSC_BIT_EXACT];
      next_cur.status = write_data[`PSC_BIT_STATUS];
    end
    // a host read is the poll that releases the interrupt; any register
    // read counts, whatever address the host named
    if (read_strobe)
      next_cur.irq = 1'b0;

    // press wins over a same-cycle clear or status write; raises the
    // interrupt from off (startup) or after power-up (shutdown request)
    if (press_edge)
    begin
      next_cur.status = 1'b1;
      if (cur.unmask && (cur.powered || cur.system_pushbutton_control == PSC_SYS_OFF))
        next_cur.irq = 1'b1;
    end

    // system state follows the channel enables; before any enable is seen,
    // letting go of the button powers down again, guarding against a tap;
    // once one is seen, only the last enable dropping ends the on state
    case (cur.system_pushbutton_control)
      PSC_SYS_OFF:
      begin
        if (pressed && !hard_hold)
          next_cur.system_pushbutton_control = PSC_SYS_ON;
      end
      PSC_SYS_ON:
      begin
        if (any_on)
          next_cur.powered = 1'b1;
        else if (cur.powered || !pressed)
        begin
          next_cur.system_pushbutton_control = PSC_SYS_OFF;
          next_cur.powered = 1'b0;
        end
      end
      default: next_cur.system_pushbutton_control = PSC_SYS_OFF;
    endcase

    // reset output timer; restarts while any hold cause stands, so a
    // bounce on release lengthens the delay rather than cutting it short;
    // runs on the system clock, so its count must follow that clock
    if (reset_hold)
    begin
      next_cur.rst_n = 1'b0;
      next_cur.timer = '0;
    end
    else if (!cur.rst_n)
    begin
      if (cur.timer >= TIMER_LAST)
        next_cur.rst_n = 1'b1;
      else
        next_cur.timer = cur.timer + psc_timer_t'(1);
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      // serial pins idle high; register fields take their reset image
      cur <= '{scl_s: 2'h3, sda_s: 2'h3,
        status: SYS_RESET[`PSC_BIT_STATUS],
        unmask: SYS_RESET[`PSC_BIT_UNMASK],
        exact: SYS_RESET[`PSC_BIT_EXACT],
        system_pushbutton_control: PSC_SYS_OFF,
        default: '0};
    end
    else
      cur <= next_cur;
  end
endmodule // psc_system_control

// >>> shared/psc_cfg.svh
/*
  Constants of the system-control block: serial target address, register
  offset and field positions, reset-timeout figures.
  Assumes inclusion by the package and the design modules of this block.
*/
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
`define PSC_TARGET_ADDR 7'h5A
`define PSC_SYS_OFFSET 8'h06
`define PSC_BIT_STATUS 0
`define PSC_BIT_UNMASK 1
`define PSC_BIT_EXACT 4
`define PSC_SYS_RESET 8'h02
`define PSC_RESET_MS 260
`define PSC_CLOCK_KHZ 100000
`define PSC_RESET_CYCLES (`PSC_RESET_MS * `PSC_CLOCK_KHZ)
`define PSC_TIMER_BITS 28
`endif

// >>> shared/psc_pkg.sv
/*
  Types shared by the system-control block.
  Assumes psc_cfg.svh is on the include path.
*/
`include "psc_cfg.svh"
package psc_pkg;
  typedef enum logic [2:0] {
    PSC_IDLE,
    PSC_ADDR,
    PSC_ADDR_ACK,
    PSC_WR_BYTE,
    PSC_WR_ACK,
    PSC_RD_BYTE,
    PSC_RD_ACK
  } psc_link_state_t;
  typedef enum logic [1:0] {
    PSC_SYS_OFF,
    PSC_SYS_ON
  } psc_sys_state_t;
endpackage
